// *** ext_end.sv ***
// external agent end: grant throttle, external write, read response
module ext_end
   import sysif_pkg::*;
#(
   parameter int AD_W = AD_WIDTH
) (
   input  wire logic            clk_sys_in,
   input  wire logic            nrst_in,
   sys_bus_if.ext_mp            bus,
   input  wire logic            grant_en_in,    // allow cpu issuance
   input  wire logic            wr_valid_in,    // external write request
   input  wire logic [AD_W-1:0] wr_addr_in,
   input  wire logic [AD_W-1:0] wr_data_in,
   output logic                 wr_ready_out,   // write done pulse
   input  wire logic            resp_valid_in,  // response word
   input  wire logic [AD_W-1:0] resp_data_in,
   input  wire logic            resp_err_in,
   input  wire logic            resp_last_in,
   output logic                 resp_ready_out, // buffer has room
   output logic                 cpu_req_out,    // cpu request seen
   output logic                 cpu_req_wr_out,
   output logic [AD_W-1:0]      cpu_req_addr_out,
   output logic [AD_W-1:0]      cpu_req_data_out,
   output logic                 rd_pending_out,
   output logic                 cpu_wants_bus_out
);
   localparam int BW = AD_W + 2;   // data, error, last
   localparam int BD = 2;          // buffer depth
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01, // slave
      ST_WAIT  = 6'h02, // request raised, waiting for release
      ST_WADDR = 6'h04, // write command cycle
      ST_WDATA = 6'h08, // write data cycle
      ST_RESP  = 6'h10, // response words
      ST_DONE  = 6'h20  // release after last word
   } ext_state_type;

   typedef struct packed {
      ext_state_type        st;
      logic                 ext_bus_request_n_n;
      logic                 grant_n;
      logic [1:0]           hold;     // remaining forced grant cycles
      logic                 gq;       // grant seen last cycle
      logic                 oe;
      logic                 valid_n;
      logic [AD_W-1:0]      ad;
      logic [4:0]           cmd;
      logic                 rd_pend;
      logic                 cwr;      // cpu write command seen
      logic [AD_W-1:0]      caddr;
      logic                 creq;
      logic                 cwr_o;
      logic [AD_W-1:0]      cdata;
      logic                 wdone;
      logic [BD-1:0][BW-1:0] mem;     // two-entry response buffer
      logic                 wp;
      logic                 rp;
      logic [1:0]           cnt;
      logic                 rdy;
      logic                 pwant;
   } ext_regs_type;

   ext_regs_type r_q;
   ext_regs_type r_d;

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      logic          push;
      logic          pop;
      logic [BW-1:0] head;
      logic          cvalid;
      push   = resp_valid_in && r_q.rdy;
      pop    = 1'b0;
      head   = r_q.mem[r_q.rp];
      cvalid = !bus.cpu_valid_strobe_n && !bus.cpu_owns_bus_n && r_q.gq;
      r_d       = r_q;
      r_d.creq  = 1'b0;
      r_d.wdone = 1'b0;
      r_d.gq    = !r_q.grant_n;
      r_d.pwant = !bus.cpu_bus_request_n;
      //---------------- grant throttle
      if (r_q.hold != CNT_ZERO) begin
         r_d.hold = r_q.hold - CNT_ONE;
      end else if (grant_en_in && r_q.grant_n) begin
         r_d.grant_n = 1'b0;
         r_d.hold    = GRANT_MIN - CNT_ONE;
      end else begin
         r_d.grant_n = !grant_en_in;
      end
      //---------------- watch issued cpu cycles
      if (cvalid && bus.sys_command_bus == CMD_READ) begin
         r_d.rd_pend = 1'b1;
         r_d.creq    = 1'b1;
         r_d.cwr_o   = 1'b0;
         r_d.caddr   = bus.sys_addr_data_bus;
      end else if (cvalid && bus.sys_command_bus == CMD_WRITE) begin
         r_d.cwr   = 1'b1;
         r_d.caddr = bus.sys_addr_data_bus;
      end else if (cvalid && r_q.cwr) begin
         r_d.cwr   = 1'b0;
         r_d.creq  = 1'b1;
         r_d.cwr_o = 1'b1;
         r_d.cdata = bus.sys_addr_data_bus;
      end
      //---------------- arbitration and requests
      case (r_q.st)
         ST_IDLE: begin
            // cpu asking back outranks a fresh write here
            if (wr_valid_in && bus.cpu_bus_request_n && !r_q.wdone) begin
               r_d.st     = ST_WAIT;
               r_d.ext_bus_request_n_n = 1'b0;
            end else if (r_q.rd_pend && bus.cpu_owns_bus_n) begin
               r_d.st = ST_RESP;
               r_d.oe = 1'b1;
            end
         end
         ST_WAIT: begin
            // drive only from the cycle after release is seen
            if (bus.cpu_owns_bus_n) begin
               r_d.st      = ST_WADDR;
               r_d.oe      = 1'b1;
               r_d.ad      = wr_addr_in;
               r_d.cmd     = CMD_WRITE;
               r_d.valid_n = 1'b0;
            end
         end
         ST_WADDR: begin
            r_d.st     = ST_WDATA;
            r_d.ad     = wr_data_in;
            r_d.cmd    = CMD_DATA_LAST;
            r_d.ext_bus_request_n_n = 1'b1;
         end
         ST_WDATA: begin
            r_d.st      = ST_IDLE;
            r_d.oe      = 1'b0;
            r_d.valid_n = 1'b1;
            r_d.wdone   = 1'b1;
         end
         ST_RESP: begin
            // a stalled source leaves the strobe off; no write enters
            if (r_q.cnt != CNT_ZERO) begin
               pop         = 1'b1;
               r_d.ad      = head[AD_W-1:0];
               r_d.cmd     = head[AD_W] ? CMD_DATA_LAST : CMD_DATA_MORE;
               r_d.cmd[CMD_ERR_BIT] = head[AD_W+1];
               r_d.valid_n = 1'b0;
               if (head[AD_W]) begin
                  r_d.st = ST_DONE;
               end
            end else begin
               r_d.valid_n = 1'b1;
            end
         end
         ST_DONE: begin
            r_d.st      = ST_IDLE;
            r_d.oe      = 1'b0;
            r_d.valid_n = 1'b1;
            r_d.rd_pend = 1'b0;
         end
         default: begin
            r_d.st = ST_IDLE;
         end
      endcase
      //---------------- buffer pointers
      if (push) begin
         r_d.mem[r_q.wp] = {resp_err_in, resp_last_in, resp_data_in};
         r_d.wp          = !r_q.wp;
      end
      if (pop) begin
         r_d.rp = !r_q.rp;
      end
      r_d.cnt = r_q.cnt + {1'b0, push} - {1'b0, pop};
      r_d.rdy = (r_d.cnt != 2'(BD));
   end

   //------------------------------------------------------------
   // state register: slave after reset
   //------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r_q         <= '0;
         r_q.st      <= ST_IDLE;
         r_q.ext_bus_request_n_n  <= 1'b1;
         r_q.grant_n <= 1'b1;
         r_q.valid_n <= 1'b1;
         r_q.rdy     <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------
   assign bus.issue_grant_n      = r_q.grant_n;
   assign bus.ext_bus_request_n  = r_q.ext_bus_request_n_n;
   assign bus.ext_valid_strobe_n = r_q.valid_n;
   assign bus.ext_ad             = r_q.ad;
   assign bus.ext_cmd            = r_q.cmd;
   assign bus.ext_oe             = r_q.oe;
   assign wr_ready_out           = r_q.wdone;
   assign resp_ready_out         = r_q.rdy;
   assign cpu_req_out            = r_q.creq;
   assign cpu_req_wr_out         = r_q.cwr_o;
   assign cpu_req_addr_out       = r_q.caddr;
   assign cpu_req_data_out       = r_q.cdata;
   assign rd_pending_out         = r_q.rd_pend;
   assign cpu_wants_bus_out      = r_q.pwant;
endmodule : ext_end

// *** sysif_pkg.sv ***
// shared constants for the system bus arbitration ends
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - cpu repeats address cycle until grant seen
// - issue ends only after grant in preceding cycle
// - agent holds grant at least two cycles
// - agent starts external request only in slave
// - cpu drops ownership after issuing a read
// - idle agent: cpu regains after read data
// - agent request held: cpu stays slave after data
// - agent requests, owns bus once cpu lets go
// - cpu regains ownership two cycles after release
// - cpu floats both buses when yielding
// - agent drives one cycle after ownership drops
// - agent drops request in final cycle, floats
// - read-won mastership only returns read data; here an external write requested before the response goes first
// - cpu asks bus back: agent holds off a new write request, keeps a bus it owns
// - reset: cpu master, agent slave
// - external write: command cycle, one tagged data
// - agent holds request through the write command cycle, releases it in the data cycle
// - no external write inside response data
// - after last data: release, cpu back two later
// - full response returned even with errors
// - erroneous response word raises bus error
// - response only while a read is pending
// - last word tagged last, others plain data
// - accept strobed data words until last tag
package sysif_pkg;
   //------------------------------------------------------------
   // bus widths
   //------------------------------------------------------------
   localparam int AD_WIDTH  = 32;
   localparam int CMD_WIDTH = 5;
   //------------------------------------------------------------
   // command bus codes; bit 4 marks a data identifier
   //------------------------------------------------------------
   localparam logic [4:0] CMD_READ      = 5'h00;
   localparam logic [4:0] CMD_WRITE     = 5'h08;
   localparam logic [4:0] CMD_DATA_LAST = 5'h10; // last word
   localparam logic [4:0] CMD_DATA_MORE = 5'h18; // further words follow
   localparam int         CMD_DATA_BIT  = 4;
   localparam int         CMD_MORE_BIT  = 3;
   localparam int         CMD_ERR_BIT   = 2;     // data marked erroneous
   //------------------------------------------------------------
   // timing counts in cycles
   //------------------------------------------------------------
   localparam logic [1:0] REGAIN_CYCLES = 2'h2; // release to ownership
   localparam logic [1:0] GRANT_MIN     = 2'h2; // least grant width
   localparam logic [1:0] CNT_ONE       = 2'h1;
   localparam logic [1:0] CNT_ZERO      = 2'h0;
   // true for any data identifier
   function automatic logic is_data_cmd(input logic [4:0] c);
      return c[CMD_DATA_BIT];
   endfunction : is_data_cmd
   // true for the last data identifier
   function automatic logic is_last_cmd(input logic [4:0] c);
      return c[CMD_DATA_BIT] && !c[CMD_MORE_BIT];
   endfunction : is_last_cmd
endpackage : sysif_pkg

// *** sys_bus_if.sv ***
// interface joining the cpu end and the external agent end
interface sys_bus_if;
   import sysif_pkg::*;
   logic                 issue_grant_n;      // agent allows issuance
   logic                 ext_bus_request_n;  // agent wants the bus
   logic                 cpu_bus_request_n;  // cpu wants the bus back
   logic                 cpu_owns_bus_n;     // cpu is master
   logic                 cpu_valid_strobe_n; // cpu cycle valid
   logic                 ext_valid_strobe_n; // agent cycle valid
   logic [AD_WIDTH-1:0]  cpu_ad;             // cpu address/data drive
   logic [CMD_WIDTH-1:0] cpu_cmd;            // cpu command drive
   logic                 cpu_oe;             // cpu drives both buses
   logic [AD_WIDTH-1:0]  ext_ad;             // agent address/data drive
   logic [CMD_WIDTH-1:0] ext_cmd;            // agent command drive
   logic                 ext_oe;             // agent drives both buses
   logic [AD_WIDTH-1:0]  sys_addr_data_bus;  // resolved bus level
   logic [CMD_WIDTH-1:0] sys_command_bus;    // resolved bus level
   // a floating bus reads as zero here
   assign sys_addr_data_bus = cpu_oe ? cpu_ad : (ext_oe ? ext_ad : '0);
   assign sys_command_bus   = cpu_oe ? cpu_cmd : (ext_oe ? ext_cmd : '0);
   modport cpu_mp (
      input  issue_grant_n, ext_bus_request_n, ext_valid_strobe_n,
      input  sys_addr_data_bus, sys_command_bus,
      output cpu_bus_request_n, cpu_owns_bus_n, cpu_valid_strobe_n,
      output cpu_ad, cpu_cmd, cpu_oe
   );
   modport ext_mp (
      input  cpu_bus_request_n, cpu_owns_bus_n, cpu_valid_strobe_n,
      input  sys_addr_data_bus, sys_command_bus,
      output issue_grant_n, ext_bus_request_n, ext_valid_strobe_n,
      output ext_ad, ext_cmd, ext_oe
   );
endinterface : sys_bus_if

// *** cpu_end.sv ***
// processor end: arbitration, request issue and response intake
module cpu_end
   import sysif_pkg::*;
#(
   parameter int AD_W = AD_WIDTH
) (
   input  wire logic            clk_sys_in,
   input  wire logic            nrst_in,          // warm reset, async
   input  wire logic            cold_restart_n,   // cold reset, sync
   sys_bus_if.cpu_mp            bus,
   input  wire logic            req_valid_in,     // user request
   input  wire logic            req_write_in,     // 1 write, 0 read
   input  wire logic [AD_W-1:0] req_addr_in,
   input  wire logic [AD_W-1:0] req_wdata_in,
   input  wire logic            want_bus_in,      // ask bus back
   output logic                 req_taken_out,    // request accepted
   output logic                 rd_valid_out,     // response word
   output logic [AD_W-1:0]      rd_data_out,
   output logic                 rd_last_out,
   output logic                 bus_error_out,    // erroneous response
   output logic                 xw_valid_out,     // external write done
   output logic [AD_W-1:0]      xw_addr_out,
   output logic [AD_W-1:0]      xw_data_out,
   output logic                 is_master_out
);
   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_MASTER = 5'h01, // owns bus, idle
      ST_ADDR   = 5'h02, // address cycle repeating
      ST_WDATA  = 5'h04, // write data cycle
      ST_SLAVE  = 5'h08, // agent owns the bus
      ST_REGAIN = 5'h10  // counting to ownership
   } cpu_state_type;

   typedef struct packed {
      cpu_state_type   st;
      logic            owns_n;   // ownership pin
      logic            oe;       // bus drive enable
      logic            valid_n;  // valid strobe pin
      logic            cpu_bus_request_n_n;   // bus request pin
      logic [AD_W-1:0] ad;
      logic [4:0]      cmd;
      logic            grant_q;  // grant seen last cycle
      logic            is_wr;
      logic [AD_W-1:0] wdata;
      logic            rd_pend;  // read outstanding
      logic            err;      // error seen in this response
      logic [1:0]      cnt;
      logic            xw_arm;   // external write command seen
      logic            taken;
      logic            rd_v;
      logic [AD_W-1:0] rd_d;
      logic            rd_l;
      logic            berr;
      logic            xw_v;
      logic [AD_W-1:0] xw_a;
      logic [AD_W-1:0] xw_d;
   } cpu_regs_type;

   cpu_regs_type r_q;  // registered state
   cpu_regs_type r_d;  // next state
   cpu_regs_type r_rst; // reset image

   //------------------------------------------------------------
   // reset image: master, buses driven idle
   //------------------------------------------------------------
   always_comb begin
      r_rst         = '0;
      r_rst.st      = ST_MASTER;
      r_rst.owns_n  = 1'b0;
      r_rst.oe      = 1'b1;
      r_rst.valid_n = 1'b1;
      r_rst.cpu_bus_request_n_n  = 1'b1;
   end

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      logic [4:0] cin;
      logic       xv;
      cin = bus.sys_command_bus;
      xv  = !bus.ext_valid_strobe_n;
      r_d = r_q;
      // one-cycle pulses fall by default
      r_d.taken   = 1'b0;
      r_d.rd_v    = 1'b0;
      r_d.rd_l    = 1'b0;
      r_d.berr    = 1'b0;
      r_d.xw_v    = 1'b0;
      r_d.grant_q = !bus.issue_grant_n;
      r_d.cpu_bus_request_n_n  = !want_bus_in;
      case (r_q.st)
         ST_MASTER: begin
            if (!bus.ext_bus_request_n) begin
               // agent asked: hand over and float both buses
               r_d.st     = ST_SLAVE;
               r_d.owns_n = 1'b1;
               r_d.oe     = 1'b0;
            end else if (req_valid_in) begin
               r_d.st      = ST_ADDR;
               r_d.ad      = req_addr_in;
               r_d.cmd     = req_write_in ? CMD_WRITE : CMD_READ;
               r_d.valid_n = 1'b0;
               r_d.is_wr   = req_write_in;
               r_d.wdata   = req_wdata_in;
               r_d.taken   = 1'b1;
            end
         end
         ST_ADDR: begin
            // held until grant was seen in the preceding cycle
            if (r_q.grant_q) begin
               if (r_q.is_wr) begin
                  r_d.st  = ST_WDATA;
                  r_d.ad  = r_q.wdata;
                  r_d.cmd = CMD_DATA_LAST;
               end else begin
                  // read issued: give up the bus unasked
                  r_d.st      = ST_SLAVE;
                  r_d.owns_n  = 1'b1;
                  r_d.oe      = 1'b0;
                  r_d.valid_n = 1'b1;
                  r_d.rd_pend = 1'b1;
                  r_d.err     = 1'b0;
               end
            end
         end
         ST_WDATA: begin
            if (r_q.grant_q) begin
               r_d.st      = ST_MASTER;
               r_d.valid_n = 1'b1;
            end
         end
         ST_SLAVE, ST_REGAIN: begin
            if (xv && is_data_cmd(cin) && r_q.xw_arm) begin
               // data cycle of an external write
               r_d.xw_arm = 1'b0;
               r_d.xw_v   = 1'b1;
               r_d.xw_d   = bus.sys_addr_data_bus;
            end else if (xv && is_data_cmd(cin) && r_q.rd_pend) begin
               // response words counted only when strobed data
               r_d.rd_v = 1'b1;
               r_d.rd_d = bus.sys_addr_data_bus;
               r_d.rd_l = is_last_cmd(cin);
               if (is_last_cmd(cin)) begin
                  r_d.rd_pend = 1'b0;
                  r_d.berr    = r_q.err || cin[CMD_ERR_BIT];
               end else begin
                  r_d.err = r_q.err || cin[CMD_ERR_BIT];
               end
            end else if (xv && cin == CMD_WRITE) begin
               r_d.xw_arm = 1'b1;
               r_d.xw_a   = bus.sys_addr_data_bus;
            end
            // ownership waits for a quiet request and no open read
            if (!bus.ext_bus_request_n || r_d.rd_pend) begin
               r_d.st = ST_SLAVE;
            end else if (r_q.st == ST_SLAVE) begin
               r_d.st  = ST_REGAIN;
               r_d.cnt = REGAIN_CYCLES - CNT_ONE;
            end else if (r_q.cnt <= CNT_ONE) begin
               r_d.st      = ST_MASTER;
               r_d.owns_n  = 1'b0;
               r_d.oe      = 1'b1;
               r_d.cnt     = CNT_ZERO;
               r_d.xw_arm  = 1'b0;
               r_d.cmd     = CMD_READ;
            end else begin
               r_d.cnt = r_q.cnt - CNT_ONE;
            end
         end
         default: begin
            r_d = r_rst;
         end
      endcase
      // cold restart forces mastership like the warm one
      if (!cold_restart_n) begin
         r_d = r_rst;
      end
   end

   //------------------------------------------------------------
   // state register
   //------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r_q         <= '0;
         r_q.st      <= ST_MASTER;
         r_q.owns_n  <= 1'b0;
         r_q.oe      <= 1'b1;
         r_q.valid_n <= 1'b1;
         r_q.cpu_bus_request_n_n  <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   //------------------------------------------------------------
   // outputs, all from flops
   //------------------------------------------------------------
   assign bus.cpu_owns_bus_n     = r_q.owns_n;
   assign bus.cpu_oe             = r_q.oe;
   assign bus.cpu_valid_strobe_n = r_q.valid_n;
   assign bus.cpu_bus_request_n  = r_q.cpu_bus_request_n_n;
   assign bus.cpu_ad             = r_q.ad;
   assign bus.cpu_cmd            = r_q.cmd;
   assign req_taken_out          = r_q.taken;
   assign rd_valid_out           = r_q.rd_v;
   assign rd_data_out            = r_q.rd_d;
   assign rd_last_out            = r_q.rd_l;
   assign bus_error_out          = r_q.berr;
   assign xw_valid_out           = r_q.xw_v;
   assign xw_addr_out            = r_q.xw_a;
   assign xw_data_out            = r_q.xw_d;
   assign is_master_out          = !r_q.owns_n;
endmodule : cpu_end

// *** sysif_assertions.sv ***
// concurrent checks on the shared bus
module sysif_assertions
   import sysif_pkg::*;
(
   input wire logic                 clk_sys_in,
   input wire logic                 nrst_in,
   input wire logic                 issue_grant_n,
   input wire logic                 ext_bus_request_n,
   input wire logic                 cpu_owns_bus_n,
   input wire logic                 cpu_valid_strobe_n,
   input wire logic                 ext_valid_strobe_n,
   input wire logic                 cpu_oe,
   input wire logic                 ext_oe,
   input wire logic [CMD_WIDTH-1:0] cpu_cmd,
   input wire logic [CMD_WIDTH-1:0] sys_command_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   // cpu address cycle; last word from the agent
   wire logic ac = !cpu_valid_strobe_n && !cpu_cmd[CMD_DATA_BIT];
   wire logic lw = !ext_valid_strobe_n && sys_command_bus[CMD_DATA_BIT] && !sys_command_bus[CMD_MORE_BIT];
   a_reset_owner: assert property ($rose(nrst_in) |-> !cpu_owns_bus_n && cpu_oe) else $error("owner");
   a_addr_hold: assert property (ac && $past(issue_grant_n)
      |=> ac && $stable(cpu_cmd)) else $error("addr");
   a_read_yield: assert property (ac && cpu_cmd == CMD_READ && !$past(issue_grant_n)
      |=> cpu_owns_bus_n && !cpu_oe) else $error("read yield");
   a_write_data: assert property (ac && cpu_cmd == CMD_WRITE && !$past(issue_grant_n)
      |=> !cpu_valid_strobe_n && cpu_cmd == CMD_DATA_LAST) else $error("write data");
   // agent drives only after a full released cycle
   a_agent_slave: assert property (ext_oe
      |-> cpu_owns_bus_n && $past(cpu_owns_bus_n)) else $error("drive");
   a_grant_two: assert property ($fell(issue_grant_n) |=> !issue_grant_n) else $error("grant");
   a_write_frame: assert property (!ext_valid_strobe_n && sys_command_bus == CMD_WRITE
      |-> !ext_bus_request_n ##1 lw) else $error("frame");
   a_regain_two: assert property ($rose(ext_bus_request_n) && cpu_owns_bus_n
      |=> cpu_owns_bus_n ##1 !cpu_owns_bus_n) else $error("regain");
   a_resp_regain: assert property (lw && ext_bus_request_n
      |-> ##2 !cpu_owns_bus_n) else $error("resume");
endmodule : sysif_assertions

// *** system_bus_arbitration_flow_tb.sv ***
// bench joining the cpu end and the agent end back to back
module system_bus_arbitration_flow_tb
   import sysif_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_in, nrst_in, req_valid_in, req_write_in, grant_en_in, wr_valid_in, be;
   logic        resp_valid_in, resp_err_in, resp_last_in, req_taken_out, rd_valid_out, rd_last_out;
   logic        bus_error_out, xw_valid_out, is_master_out, wr_ready_out, resp_ready_out, cpu_req_out;
   logic        cpu_req_wr_out, rd_pending_out, cpu_wants_bus_out, wb;
   logic [31:0] req_addr_in, req_wdata_in, wr_addr_in, wr_data_in, resp_data_in, rd_data_out, xa, xd;
   logic [31:0] xw_addr_out, xw_data_out, cpu_req_addr_out, cpu_req_data_out, rq[$];
   int          num_errors = 0;
   int          comparisons = 0;
   sys_bus_if sys_bus_if_i ();
   cpu_end cpu_end_i (.cold_restart_n(1'h1), .want_bus_in(wb), .bus(sys_bus_if_i), .*);
   ext_end ext_end_i (.bus(sys_bus_if_i), .*);
   sysif_assertions sysif_assertions_i (.clk_sys_in, .nrst_in, .issue_grant_n(sys_bus_if_i.issue_grant_n),
      .ext_bus_request_n(sys_bus_if_i.ext_bus_request_n), .cpu_owns_bus_n(sys_bus_if_i.cpu_owns_bus_n),
      .cpu_valid_strobe_n(sys_bus_if_i.cpu_valid_strobe_n), .ext_valid_strobe_n(sys_bus_if_i.ext_valid_strobe_n),
      .cpu_oe(sys_bus_if_i.cpu_oe), .ext_oe(sys_bus_if_i.ext_oe), .cpu_cmd(sys_bus_if_i.cpu_cmd),
      .sys_command_bus(sys_bus_if_i.sys_command_bus));
   initial begin
      clk_sys_in = 1'h0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   // pulses are sampled settled, at the falling edge
   always @(negedge clk_sys_in) begin
      if (xw_valid_out === 1'h1) {xa, xd} = {xw_addr_out, xw_data_out};
      if (rd_valid_out === 1'h1) rq.push_back(rd_data_out);
      if (bus_error_out === 1'h1) be = rd_last_out;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // bounded wait; running out is a mismatch and ends the run
   task automatic await(ref logic s, input string n);
      for (int i = 0; i < 400; i++) begin
         @(negedge clk_sys_in);
         if (s === 1'h1) return;
      end
      chk(n, 32'h1, 32'h0);
      wrap_up();
   endtask : await
   // one response word, held until taken
   task automatic send(input logic [31:0] d, input logic e, input logic l);
      resp_data_in <= d;
      resp_err_in <= e;
      resp_last_in <= l;
      resp_valid_in <= 1'h1;
      await(resp_ready_out, "resp ready");
      @(posedge clk_sys_in);
   endtask : send
   // cpu request held until taken, judged at the agent unless hold is set
   task automatic cpu_req(input logic w, input logic [31:0] a, input bit hold);
      @(posedge clk_sys_in);
      {req_write_in, req_addr_in, req_wdata_in, req_valid_in} <= {w, a, ~a, 1'h1};
      await(req_taken_out, "req taken");
      @(posedge clk_sys_in);
      req_valid_in <= 1'h0;
      if (hold) return;
      await(cpu_req_out, "cpu req");
      chk("req kind", w, cpu_req_wr_out);
      chk("req addr", a, cpu_req_addr_out);
      if (w) chk("req data", ~a, cpu_req_data_out);
   endtask : cpu_req
   // read held off by the grant while the buffer fills; first word erroneous
   task automatic t_read();
      @(posedge clk_sys_in);
      grant_en_in <= 1'h0;
      cpu_req(1'h0, 32'h0000_0040, 1'b1);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) begin
            resp_valid_in <= 1'h0;
            @(negedge clk_sys_in);
            chk("buffer ready", 1'h0, resp_ready_out);
            @(posedge clk_sys_in);
            grant_en_in <= 1'h1;
            await(cpu_req_out, "read issued");
            chk("read addr", 32'h0000_0040, cpu_req_addr_out);
            chk("pending", 1'h1, rd_pending_out);
            @(posedge clk_sys_in);
         end
         send({8{4'(i + 1)}}, i == 0, i == 2);
      end
      resp_valid_in <= 1'h0;
      await(is_master_out, "master back");
      for (int i = 0; i < 3; i++) chk("resp word", {8{4'(i + 1)}}, rq[i]);
      chk("bus error", 1'h1, be);
      $display("test read done");
   endtask : t_read
   // external write; cpu slave until two cycles after data
   task automatic t_xwrite();
      @(posedge clk_sys_in);
      {wr_addr_in, wr_data_in, wr_valid_in} <= {32'h0000_0080, 32'h5a5a_a5a5, 1'h1};
      await(wr_ready_out, "write done");
      chk("slave in write", 1'h0, is_master_out);
      @(posedge clk_sys_in);
      wr_valid_in <= 1'h0;
      await(is_master_out, "master back");
      chk("xw addr", 32'h0000_0080, xa);
      chk("xw data", 32'h5a5a_a5a5, xd);
      @(posedge clk_sys_in) wb <= 1'h1;
      repeat (3) @(negedge clk_sys_in);
      chk("cpu wants bus", 1'h1, cpu_wants_bus_out);
      $display("test external write done");
   endtask : t_xwrite
   initial begin
      {nrst_in, req_valid_in, req_write_in, grant_en_in, wr_valid_in, be, wb} = '0;
      {resp_valid_in, resp_err_in, resp_last_in, req_addr_in, req_wdata_in, wr_addr_in, wr_data_in} = '0;
      resp_data_in = '0;
      repeat (16) @(posedge clk_sys_in);
      nrst_in <= 1'h1;
      @(negedge clk_sys_in);
      chk("master at reset", 1'h1, is_master_out);
      t_read();
      cpu_req(1'h1, 32'h0000_0100, 1'b0);
      $display("test cpu write done");
      t_xwrite();
      wrap_up();
   end
endmodule : system_bus_arbitration_flow_tb
